//--- verilog/mdua_consts.svh
// Register map, field positions, reset values and timing figures of the PHY access engine
`ifndef MDUA_CONSTS_SVH
`define MDUA_CONSTS_SVH

// -----------------------------------------------------------------------------
// Register byte offsets
// -----------------------------------------------------------------------------
`define MDUA_OFS_CTRL 5'h00
`define MDUA_OFS_REQ0 5'h04
`define MDUA_OFS_REQ1 5'h08
`define MDUA_OFS_RAW 5'h0c
`define MDUA_OFS_MASKED 5'h10
`define MDUA_OFS_MASK 5'h14
`define MDUA_OFS_RESPONDED_PHY_MAP 5'h18

// -----------------------------------------------------------------------------
// Field positions
// -----------------------------------------------------------------------------
`define MDUA_CTRL_EN 0
`define MDUA_CTRL_PRE 1
`define MDUA_CTRL_DIV_LO 8
`define MDUA_CTRL_DIV_HI 15
`define MDUA_REQ_GO 31
`define MDUA_REQ_WR 30
`define MDUA_REQ_ACK 29
`define MDUA_REQ_REG_LO 21
`define MDUA_REQ_REG_HI 25
`define MDUA_REQ_PHY_LO 16
`define MDUA_REQ_PHY_HI 20

// -----------------------------------------------------------------------------
// Reset values and timing
// -----------------------------------------------------------------------------
`define MDUA_RST_DIV 8'h09
`define MDUA_RST_PRE 1'b1
`define MDUA_CLK_HZ 20000000
`define MDUA_MDC_MAX_HZ 2500000
`define MDUA_TURN_BIT 15
`define MDUA_DATA_BIT 16
`define MDUA_DRIVE_BITS 14

`endif

//--- verilog/mdua_pkg.sv
// Types shared by the PHY access engine
package mdua_pkg;
    typedef enum logic [1:0] {
        MDUA_IDLE = 2'b00,
        MDUA_RUN = 2'b01,
        MDUA_DONE = 2'b10
    } mdua_state_t;
endpackage

//--- verilog/mdua_clkdiv.sv
// Management clock divider with rise and fall enable pulses
`timescale 1ns/1ns
`default_nettype none
module mdua_clkdiv (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic run,
    input wire logic [7:0] limit,
    output logic level,
    output logic rise,
    output logic fall
);
    logic [7:0] cnt_reg;
    logic [7:0] cnt_next;
    logic level_reg;
    logic level_next;
    logic tick;

    always_comb begin
        tick = run && (cnt_reg == limit);
        rise = tick && !level_reg;
        fall = tick && level_reg;
        cnt_next = (!run || tick) ? 8'h00 : cnt_reg + 8'h01;
        level_next = !run ? 1'b0 : (tick ? !level_reg : level_reg);
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cnt_reg <= 8'h00;
            level_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            level_reg <= level_next;
        end
    end

    assign level = level_reg;
endmodule
`default_nettype wire

//--- verilog/mdua_engine.sv
// PHY register access engine with Avalon-MM registers and management frame sequencer
`timescale 1ns/1ns
`default_nettype none
`include "mdua_consts.svh"

// Summary of operation
// - One write with launch set, direction clear, addresses starts a read.
// - Read result goes into the data field of the issuing request.
// - Completion clears launch; acknowledge set only on a successful read.
// - Completion sets the raw done bit of the issuing request.
// - Enabled mask bit sets masked done bit and raises the interrupt.
// - One write with launch and direction set and data starts a write.
// - Two pending requests are served one at a time round-robin.
// - Every user read updates the responded-map bit of that PHY.
// - Management clock is a programmed divide-down, never above 2.5 MHz.
module mdua_engine
    import mdua_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic mgmt_clock_pin,
    input wire logic mdio_in,
    output logic mdio_out,
    output logic mdio_oe,
    output logic irq
);
    localparam int MIN_HALF = (`MDUA_CLK_HZ + 2 * `MDUA_MDC_MAX_HZ - 1) / (2 * `MDUA_MDC_MAX_HZ);
    localparam logic [7:0] MIN_LIMIT = 8'(MIN_HALF - 1);

    mdua_state_t state_reg, state_next;
    logic ctrl_en_reg, ctrl_en_next, pre_reg, pre_next;
    logic [7:0] div_reg, div_next, limit;
    logic [31:0] req_reg [2];
    logic [31:0] req_next [2];
    logic [1:0] raw_reg, raw_next, mask_reg, mask_next;
    logic [31:0] responded_phy_map_reg, responded_phy_map_next;
    logic sel_reg, sel_next, last_reg, last_next;
    logic pre_run_reg, pre_run_next;
    logic [6:0] cnt_reg, cnt_next, pos;
    logic [31:0] shift_reg, shift_next;
    logic [15:0] rx_reg, rx_next;
    logic ack_reg, ack_next;
    logic mdo_reg, mdo_next, oe_reg, oe_next;
    logic wait_reg, wait_next, irq_reg, irq_next;
    logic [31:0] rdata_reg, rdata_next;
    logic sync1_reg, sync2_reg;
    logic mdc_rise, mdc_fall, wr_go;
    logic [31:0] cur;
    logic [1:0] pend;

    // -------------------------------------------------------------------------
    // Pin synchroniser and clock divider
    // -------------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sync1_reg <= 1'b1;
            sync2_reg <= 1'b1;
        end else begin
            sync1_reg <= mdio_in;
            sync2_reg <= sync1_reg;
        end
    end

    assign limit = (div_reg < MIN_LIMIT) ? MIN_LIMIT : div_reg;

    mdua_clkdiv u_div (
        .clk(clk),
        .sys_rst(sys_rst),
        .run(state_reg == MDUA_RUN),
        .limit(limit),
        .level(mgmt_clock_pin),
        .rise(mdc_rise),
        .fall(mdc_fall)
    );

    // -------------------------------------------------------------------------
    // Next-state logic
    // -------------------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        ctrl_en_next = ctrl_en_reg;
        pre_next = pre_reg;
        div_next = div_reg;
        req_next[0] = req_reg[0];
        req_next[1] = req_reg[1];
        raw_next = raw_reg;
        mask_next = mask_reg;
        responded_phy_map_next = responded_phy_map_reg;
        sel_next = sel_reg;
        last_next = last_reg;
        pre_run_next = pre_run_reg;
        cnt_next = cnt_reg;
        shift_next = shift_reg;
        rx_next = rx_reg;
        ack_next = ack_reg;
        mdo_next = mdo_reg;
        oe_next = oe_reg;
        wait_next = 1'b1;
        rdata_next = rdata_reg;
        cur = req_reg[sel_reg];
        pend = {req_reg[1][`MDUA_REQ_GO], req_reg[0][`MDUA_REQ_GO]};
        pos = cnt_reg - (pre_run_reg ? 7'd32 : 7'd0);
        wr_go = avs_write && !wait_reg && (avs_byteenable == 4'hf);

        // Bus slave: answer one cycle after the request is seen
        if ((avs_read || avs_write) && wait_reg) begin
            wait_next = 1'b0;
            case (avs_address)
                `MDUA_OFS_CTRL: rdata_next = {16'h0000, div_reg, 6'h00, pre_reg, ctrl_en_reg};
                `MDUA_OFS_REQ0: rdata_next = req_reg[0];
                `MDUA_OFS_REQ1: rdata_next = req_reg[1];
                `MDUA_OFS_RAW: rdata_next = {30'h0, raw_reg};
                `MDUA_OFS_MASKED: rdata_next = {30'h0, raw_reg & mask_reg};
                `MDUA_OFS_MASK: rdata_next = {30'h0, mask_reg};
                `MDUA_OFS_RESPONDED_PHY_MAP: rdata_next = responded_phy_map_reg;
                default: rdata_next = 32'h0000_0000;
            endcase
        end
        if (wr_go) begin
            case (avs_address)
                `MDUA_OFS_CTRL: begin
                    ctrl_en_next = avs_writedata[`MDUA_CTRL_EN];
                    pre_next = avs_writedata[`MDUA_CTRL_PRE];
                    div_next = avs_writedata[`MDUA_CTRL_DIV_HI:`MDUA_CTRL_DIV_LO];
                end
                `MDUA_OFS_REQ0, `MDUA_OFS_REQ1: begin
                    // A request that is still in flight is protected
                    if (!req_reg[avs_address[3]][`MDUA_REQ_GO]) begin
                        req_next[avs_address[3]] = {avs_writedata[31:30], 4'h0, avs_writedata[25:0]};
                    end
                end
                `MDUA_OFS_RAW: raw_next = raw_reg & ~avs_writedata[1:0];
                `MDUA_OFS_MASK: mask_next = avs_writedata[1:0];
                default: begin
                end
            endcase
        end

        // Frame sequencer
        case (state_reg)
            MDUA_IDLE: begin
                if (ctrl_en_reg && (pend != 2'b00)) begin
                    sel_next = (pend == 2'b11) ? !last_reg : pend[1];
                    cur = req_reg[sel_next];
                    pre_run_next = pre_reg;
                    cnt_next = 7'd0;
                    ack_next = 1'b0;
                    mdo_next = 1'b1;
                    oe_next = 1'b1;
                    shift_next = {2'b01, cur[`MDUA_REQ_WR] ? 2'b01 : 2'b10,
                                  cur[`MDUA_REQ_PHY_HI:`MDUA_REQ_PHY_LO],
                                  cur[`MDUA_REQ_REG_HI:`MDUA_REQ_REG_LO],
                                  cur[`MDUA_REQ_WR] ? 2'b10 : 2'b11,
                                  cur[`MDUA_REQ_WR] ? cur[15:0] : 16'hffff};
                    state_next = MDUA_RUN;
                end
            end
            MDUA_RUN: begin
                if (mdc_rise && (cnt_reg > (pre_run_reg ? 7'd32 : 7'd0))) begin
                    if (pos - 7'd1 == 7'(`MDUA_TURN_BIT)) begin
                        ack_next = !sync2_reg;
                    end
                    if (pos - 7'd1 >= 7'(`MDUA_DATA_BIT)) begin
                        rx_next = {rx_reg[14:0], sync2_reg};
                    end
                end
                if (mdc_fall) begin
                    if (cnt_reg == (pre_run_reg ? 7'd64 : 7'd32)) begin
                        oe_next = 1'b0;
                        mdo_next = 1'b1;
                        state_next = MDUA_DONE;
                    end else begin
                        cnt_next = cnt_reg + 7'd1;
                        if (pre_run_reg && (cnt_reg < 7'd32)) begin
                            mdo_next = 1'b1;
                        end else begin
                            mdo_next = shift_reg[31];
                            shift_next = {shift_reg[30:0], 1'b1};
                            oe_next = cur[`MDUA_REQ_WR] || (pos < 7'(`MDUA_DRIVE_BITS));
                        end
                    end
                end
            end
            MDUA_DONE: begin
                req_next[sel_reg][`MDUA_REQ_GO] = 1'b0;
                req_next[sel_reg][`MDUA_REQ_ACK] = !cur[`MDUA_REQ_WR] && ack_reg;
                if (!cur[`MDUA_REQ_WR]) begin
                    req_next[sel_reg][15:0] = rx_reg;
                    responded_phy_map_next[cur[`MDUA_REQ_PHY_HI:`MDUA_REQ_PHY_LO]] = ack_reg;
                end
                raw_next[sel_reg] = 1'b1;
                last_next = sel_reg;
                state_next = MDUA_IDLE;
            end
            default: state_next = MDUA_IDLE;
        endcase
        irq_next = |(raw_next & mask_next);
    end

    // -------------------------------------------------------------------------
    // State registers
    // -------------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_reg <= MDUA_IDLE;
            ctrl_en_reg <= 1'b0;
            pre_reg <= `MDUA_RST_PRE;
            div_reg <= `MDUA_RST_DIV;
            req_reg[0] <= 32'h0000_0000;
            req_reg[1] <= 32'h0000_0000;
            raw_reg <= 2'h0;
            mask_reg <= 2'h0;
            responded_phy_map_reg <= 32'h0000_0000;
            sel_reg <= 1'b0;
            last_reg <= 1'b1;
            pre_run_reg <= 1'b0;
            cnt_reg <= 7'h00;
            shift_reg <= 32'hffff_ffff;
            rx_reg <= 16'h0000;
            ack_reg <= 1'b0;
            mdo_reg <= 1'b1;
            oe_reg <= 1'b0;
            wait_reg <= 1'b1;
            rdata_reg <= 32'h0000_0000;
            irq_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            ctrl_en_reg <= ctrl_en_next;
            pre_reg <= pre_next;
            div_reg <= div_next;
            req_reg[0] <= req_next[0];
            req_reg[1] <= req_next[1];
            raw_reg <= raw_next;
            mask_reg <= mask_next;
            responded_phy_map_reg <= responded_phy_map_next;
            sel_reg <= sel_next;
            last_reg <= last_next;
            pre_run_reg <= pre_run_next;
            cnt_reg <= cnt_next;
            shift_reg <= shift_next;
            rx_reg <= rx_next;
            ack_reg <= ack_next;
            mdo_reg <= mdo_next;
            oe_reg <= oe_next;
            wait_reg <= wait_next;
            rdata_reg <= rdata_next;
            irq_reg <= irq_next;
        end
    end

    assign avs_readdata = rdata_reg;
    assign avs_waitrequest = wait_reg;
    assign mdio_out = mdo_reg;
    assign mdio_oe = oe_reg;
    assign irq = irq_reg;

    // -------------------------------------------------------------------------
    // Assertions
    // -------------------------------------------------------------------------
    sequence s_finish;
        state_reg == MDUA_RUN ##1 state_reg == MDUA_DONE;
    endsequence

    a_launch_start: assert property (@(posedge clk) disable iff (sys_rst)
        (state_reg == MDUA_IDLE && ctrl_en_reg && pend != 2'b00) |=> state_reg == MDUA_RUN)
        else $error("pending launch did not start a frame");
    a_done_clears: assert property (@(posedge clk) disable iff (sys_rst)
        s_finish |=> !req_reg[sel_reg][`MDUA_REQ_GO])
        else $error("launch bit not cleared at completion");
    a_raw_event: assert property (@(posedge clk) disable iff (sys_rst)
        s_finish |=> raw_reg[sel_reg])
        else $error("raw done bit not set for issuing request");
    a_irq_masked: assert property (@(posedge clk) disable iff (sys_rst)
        irq_reg == |(raw_reg & mask_reg))
        else $error("interrupt disagrees with masked done bits");
    a_read_data: assert property (@(posedge clk) disable iff (sys_rst)
        (state_reg == MDUA_DONE && !cur[`MDUA_REQ_WR]) |=> req_reg[sel_reg][15:0] == $past(rx_reg))
        else $error("read data not returned to request");
    a_responded_phy_map_map: assert property (@(posedge clk) disable iff (sys_rst)
        (state_reg == MDUA_DONE && !cur[`MDUA_REQ_WR])
        |=> responded_phy_map_reg[req_reg[sel_reg][`MDUA_REQ_PHY_HI:`MDUA_REQ_PHY_LO]] == $past(ack_reg))
        else $error("responded map not updated by read");
    a_rr_order: assert property (@(posedge clk) disable iff (sys_rst)
        (state_reg == MDUA_IDLE && ctrl_en_reg && pend == 2'b11) |=> sel_reg != $past(last_reg))
        else $error("round-robin order broken");
    a_mdc_rate: assert property (@(posedge clk) disable iff (sys_rst)
        $rose(mgmt_clock_pin) |-> mgmt_clock_pin [*4])
        else $error("management clock high phase too short");
endmodule
`default_nettype wire

//--- test/mdua_phy_model.sv
// Behavioural PHY on the management bus
`timescale 1ns/1ns
`default_nettype none
module mdua_phy_model #(
    parameter logic [4:0] PHY_ADDR = 5'h05
) (
    input wire logic mgmt_clock_pin,
    input wire logic mdio,
    output logic drv_out,
    output logic drv_oe
);
    logic [15:0] regs [32];
    logic [12:0] hdr;
    logic [15:0] word;
    // ----
    // Frame decoder
    // ----
    initial begin
        for (int i = 0; i < 32; i++) begin
            regs[i] = 16'ha5c3 ^ 16'(i);
        end
        hdr = 13'h0;
        drv_out = 1'b1;
        drv_oe = 1'b0;
        forever begin
            @(posedge mgmt_clock_pin);
            if (mdio === 1'b0) begin
                for (int i = 0; i < 13; i++) begin
                    @(posedge mgmt_clock_pin);
                    hdr = {hdr[11:0], mdio};
                end
                if (hdr[12] === 1'b1 && hdr[11:10] === 2'b10 && hdr[9:5] === PHY_ADDR) begin
                    word = regs[hdr[4:0]];
                    repeat (2) @(negedge mgmt_clock_pin);
                    drv_oe = 1'b1;
                    drv_out = 1'b0;
                    for (int i = 15; i >= 0; i--) begin
                        @(negedge mgmt_clock_pin);
                        drv_out = word[i];
                    end
                    @(negedge mgmt_clock_pin);
                    drv_oe = 1'b0;
                end else begin
                    repeat (2) @(posedge mgmt_clock_pin);
                    for (int i = 0; i < 16; i++) begin
                        @(posedge mgmt_clock_pin);
                        word = {word[14:0], mdio};
                    end
                    if (hdr[12] === 1'b1 && hdr[11:10] === 2'b01 && hdr[9:5] === PHY_ADDR) begin
                        regs[hdr[4:0]] = word;
                    end
                end
            end
        end
    end
endmodule
`default_nettype wire

//--- test/mdio_user_access_engine_test.sv
// Self-checking bench of the PHY access engine
`timescale 1ns/1ns
`default_nettype none
`include "mdua_consts.svh"
module mdio_user_access_engine_test;
    import mdua_pkg::*;
    localparam logic [4:0] PA = 5'h05;
    logic clk, sys_rst, avs_read, avs_write, avs_waitrequest, mgmt_clock_pin, mdio_out, mdio_oe, irq;
    logic [4:0] avs_address, rg, rb;
    logic [31:0] avs_writedata, avs_readdata, q;
    logic [3:0] avs_byteenable;
    logic [15:0] dt;
    logic phy_out, phy_oe, mdio_wire;
    int miscompares, checked, hi_cnt;
    int mirror [32];
    // Pull-up holds the released line high
    assign mdio_wire = mdio_oe ? mdio_out : (phy_oe ? phy_out : 1'b1);
    mdua_engine dut_u (.clk(clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .mgmt_clock_pin(mgmt_clock_pin),
        .mdio_in(mdio_wire), .mdio_out(mdio_out), .mdio_oe(mdio_oe), .irq(irq));
    mdua_phy_model #(.PHY_ADDR(PA)) phy_u (.mgmt_clock_pin(mgmt_clock_pin), .mdio(mdio_wire),
        .drv_out(phy_out), .drv_oe(phy_oe));
    // ----
    // Tasks
    // ----
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %0t %s: %h vs %h", $time, what, seen, exp);
        end
    endtask
    task results;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        int n;
        n = 0;
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        @(posedge clk);
        while (avs_waitrequest !== 1'b0 && n < 20) begin
            @(posedge clk);
            n++;
        end
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (n >= 20) begin
            check(32'h1, 32'h0, "bus timeout");
            results();
        end
        @(posedge clk);
    endtask
    task wait_idle(input logic [4:0] a);
        int n;
        n = 0;
        bus(1'b0, a, 32'h0);
        while (q[31] !== 1'b0 && n < 400) begin
            bus(1'b0, a, 32'h0);
            n++;
        end
        if (n >= 400) begin
            check(32'h1, 32'h0, "busy timeout");
            results();
        end
    endtask
    task launch(input logic [4:0] a, input logic wr, input logic [4:0] r, input logic [4:0] p,
        input logic [15:0] d);
        wait_idle(a);
        bus(1'b1, a, {1'b1, wr, 4'h0, r, p, d});
    endtask
    task rd_expect(input logic [4:0] a, input logic [4:0] r, input logic [4:0] p);
        wait_idle(a);
        check(q & 32'he3ff_ffff, {3'b001, 3'h0, r, p, 16'(mirror[r])}, "read");
    endtask
    task done_check(input logic [1:0] raw, input logic [1:0] msk);
        bus(1'b0, `MDUA_OFS_RAW, 32'h0);
        check(q, {30'h0, raw}, "raw");
        bus(1'b0, `MDUA_OFS_MASKED, 32'h0);
        check(q, {30'h0, msk}, "masked");
        check({31'h0, irq}, {31'h0, |msk}, "irq");
        bus(1'b1, `MDUA_OFS_RAW, {30'h0, raw});
        bus(1'b0, `MDUA_OFS_RAW, 32'h0);
        check({29'h0, q[1:0], irq}, 32'h0, "clear");
    endtask
    // ----
    // Clock and stimulus
    // ----
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        if (mgmt_clock_pin === 1'b1) begin
            hi_cnt++;
        end else if (hi_cnt != 0) begin
            check(32'(hi_cnt), 32'h4, "mdc high");
            hi_cnt = 0;
        end
    end
    initial begin
        sys_rst = 1'b1;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 5'h00;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hf;
        miscompares = 0;
        checked = 0;
        hi_cnt = 0;
        void'($urandom(33230));
        for (int i = 0; i < 32; i++) begin
            mirror[i] = 32'ha5c3 ^ i;
        end
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            bus(1'b0, 5'(4 * i), 32'h0);
            check(q, (i == 0) ? 32'h0000_0902 : 32'h0, "reset");
        end
        check({31'h0, irq}, 32'h0, "irq reset");
        bus(1'b1, `MDUA_OFS_MASK, 32'h1);
        for (int k = 0; k < 3; k++) begin
            // Divide 3, 2, 1 must all give the same bus rate
            bus(1'b1, `MDUA_OFS_CTRL, {16'h0, 8'(3 - k), 6'h0, k[0], 1'b1});
            rg = 5'($urandom);
            dt = 16'($urandom);
            mirror[rg] = dt;
            launch(`MDUA_OFS_REQ0, 1'b1, rg, PA, dt);
            wait_idle(`MDUA_OFS_REQ0);
            check(q & 32'he000_0000, 32'h4000_0000, "write done");
            done_check(2'b01, 2'b01);
            launch(`MDUA_OFS_REQ0, 1'b0, rg, PA, 16'h0);
            rd_expect(`MDUA_OFS_REQ0, rg, PA);
            done_check(2'b01, 2'b01);
        end
        launch(`MDUA_OFS_REQ0, 1'b0, rg, PA + 5'h1, 16'h0);
        wait_idle(`MDUA_OFS_REQ0);
        check(q & 32'he000_0000, 32'h0, "no ack");
        done_check(2'b01, 2'b01);
        bus(1'b0, `MDUA_OFS_RESPONDED_PHY_MAP, 32'h0);
        check(q, 32'h1 << PA, "responded_phy_map");
        bus(1'b1, `MDUA_OFS_CTRL, 32'h0000_0302);
        rb = rg + 5'h1;
        launch(`MDUA_OFS_REQ0, 1'b0, rg, PA, 16'h0);
        launch(`MDUA_OFS_REQ1, 1'b0, rb, PA, 16'h0);
        bus(1'b1, `MDUA_OFS_CTRL, 32'h0000_0303);
        rd_expect(`MDUA_OFS_REQ1, rb, PA);
        bus(1'b0, `MDUA_OFS_REQ0, 32'h0);
        check({31'h0, q[31]}, 32'h1, "second pending");
        rd_expect(`MDUA_OFS_REQ0, rg, PA);
        done_check(2'b11, 2'b01);
        results();
    end
endmodule
`default_nettype wire
